/* cspr_core_regs.sv */
// core special registers: stack, data pointer, status word, accumulator
`timescale 1ns/10ps
module cspr_core_regs (
   // clock and reset
   input wire logic sys_clk_i,
   input wire logic rst_i,
   // special register space access
   input wire cspr_pkg::cspr_sfr_t sfr_i,
   input wire logic [7:0] sfr_raddr_i,
   output logic [7:0] sfr_rdata_o,
   output logic sfr_hit_o,
   // datapath writes and flag updates
   input wire logic acc_wr_i,
   input wire logic [7:0] acc_wdata_i,
   input wire logic alu_valid_i,
   input wire cspr_pkg::cspr_alu_t alu_i,
   input wire logic push_i,
   input wire logic pop_i,
   // register state seen by the datapath
   output logic [7:0] acc_o,
   output logic [7:0] status_o,
   output logic [15:0] indirect_data_pointer_o,
   output logic [7:0] stack_top_pointer_o,
   output logic [7:0] push_addr_o,
   output logic [4:0] bank_base_o
);
   // =======================================================
   // state
   logic [7:0] data_pointer_low;
   logic [7:0] data_pointer_high;
   logic [7:0] main_work_register;
   logic [7:0] status_sw; // bits 7..1, bit 0 unused
   logic [7:0] next_data_pointer_low;
   logic [7:0] next_data_pointer_high;
   logic [7:0] next_main_work_register;
   logic [7:0] next_status_sw;
   logic [7:0] next_status;
   logic [7:0] next_rdata;
   logic next_hit;
   logic stack_load;

   // byte write or single bit write merged into the old value
   function automatic logic [7:0] merge_write(input logic [7:0] old,
                                              input cspr_pkg::cspr_sfr_t s);
      logic [7:0] v;
      v = old;
      if (s.wr) begin
         v = s.wdata;
      end else if (s.bit_wr) begin
         v[s.bit_sel] = s.bit_val;
      end
      return v;
   endfunction

   // software write strobe to a fixed address, page is ignored
   function automatic logic hit_wr(input cspr_pkg::cspr_sfr_t s,
                                   input logic [7:0] a);
      return (s.wr || s.bit_wr) && s.addr == a; // see RL13
   endfunction

   // =======================================================
   // stack pointer
   assign stack_load = hit_wr(sfr_i, cspr_pkg::ADDR_STACK_TOP) && sfr_i.wr;

   cspr_stack #(
      .RESET_VALUE(cspr_pkg::RST_STACK_TOP)
   ) u_stack (
      .sys_clk_i(sys_clk_i),
      .rst_i(rst_i),
      .push_i(push_i),
      .pop_i(pop_i),
      .load_i(stack_load),
      .load_val_i(sfr_i.wdata),
      .ptr_o(stack_top_pointer_o),
      .push_addr_o(push_addr_o)
   );

   // =======================================================
   // next values of data pointer, accumulator and status word
   always_comb begin
      next_data_pointer_low = data_pointer_low;
      next_data_pointer_high = data_pointer_high;
      if (hit_wr(sfr_i, cspr_pkg::ADDR_INDIRECT_DATA_POINTER_LOW)) begin
         next_data_pointer_low = merge_write(data_pointer_low, sfr_i);
      end
      if (hit_wr(sfr_i, cspr_pkg::ADDR_INDIRECT_DATA_POINTER_HIGH)) begin
         next_data_pointer_high = merge_write(data_pointer_high, sfr_i);
      end
      // accumulator: datapath result wins over software write
      next_main_work_register = main_work_register;
      if (hit_wr(sfr_i, cspr_pkg::ADDR_WORK)) begin
         next_main_work_register = merge_write(main_work_register, sfr_i);
      end
      if (acc_wr_i) begin
         next_main_work_register = acc_wdata_i; // see RL12
      end
      // software writes; parity bit is never stored
      next_status_sw = status_sw;
      if (hit_wr(sfr_i, cspr_pkg::ADDR_STATUS)) begin
         next_status_sw = merge_write(status_sw, sfr_i)
                          & cspr_pkg::STATUS_SW_MASK; // see RL6
      end
      // arithmetic flag updates win over software
      if (alu_valid_i && alu_i.op != cspr_pkg::CSPR_OP_NONE) begin
         next_status_sw[cspr_pkg::BIT_CARRY] = alu_i.carry; // see RL4
         next_status_sw[cspr_pkg::BIT_HALF] = alu_i.half_carry; // see RL5
         unique case (alu_i.op)
            cspr_pkg::CSPR_OP_ADD, cspr_pkg::CSPR_OP_ADDC,
            cspr_pkg::CSPR_OP_SUBB: begin
               next_status_sw[cspr_pkg::BIT_OVFL] = alu_i.sign_ovfl; // see RL8
            end
            cspr_pkg::CSPR_OP_MUL: begin
               next_status_sw[cspr_pkg::BIT_OVFL] =
                  alu_i.product[15:8] != 8'h00; // see RL8
            end
            cspr_pkg::CSPR_OP_DIV: begin
               next_status_sw[cspr_pkg::BIT_OVFL] =
                  alu_i.divisor == cspr_pkg::RST_ZERO; // see RL9
            end
            default: begin
            end
         endcase
      end
      // parity follows the accumulator value being registered
      next_status = next_status_sw;
      next_status[cspr_pkg::BIT_PARITY] = ^next_main_work_register; // see RL10
   end

   // =======================================================
   // read decode at fixed addresses
   always_comb begin
      next_hit = 1'b1;
      unique case (sfr_raddr_i)
         cspr_pkg::ADDR_STACK_TOP: next_rdata = stack_top_pointer_o;
         cspr_pkg::ADDR_INDIRECT_DATA_POINTER_LOW: next_rdata = data_pointer_low;
         cspr_pkg::ADDR_INDIRECT_DATA_POINTER_HIGH: next_rdata = data_pointer_high;
         cspr_pkg::ADDR_STATUS: next_rdata = status_o;
         cspr_pkg::ADDR_WORK: next_rdata = main_work_register;
         default: begin
            next_rdata = cspr_pkg::RST_ZERO;
            next_hit = 1'b0;
         end
      endcase
   end

   // register everything
   always_ff @(posedge sys_clk_i) begin
      if (rst_i) begin
         data_pointer_low <= cspr_pkg::RST_ZERO;
         data_pointer_high <= cspr_pkg::RST_ZERO;
         main_work_register <= cspr_pkg::RST_ZERO; // see RL12
         status_sw <= cspr_pkg::RST_ZERO; // see RL11
         status_o <= cspr_pkg::RST_ZERO;
         acc_o <= cspr_pkg::RST_ZERO;
         indirect_data_pointer_o <= {cspr_pkg::RST_ZERO, cspr_pkg::RST_ZERO};
         bank_base_o <= 5'h00;
         sfr_rdata_o <= cspr_pkg::RST_ZERO;
         sfr_hit_o <= 1'b0;
      end else begin
         data_pointer_low <= next_data_pointer_low;
         data_pointer_high <= next_data_pointer_high;
         main_work_register <= next_main_work_register;
         status_sw <= next_status_sw;
         status_o <= next_status;
         acc_o <= next_main_work_register;
         indirect_data_pointer_o <= {next_data_pointer_high,
                                     next_data_pointer_low}; // see RL3
         bank_base_o <= {next_status[cspr_pkg::BIT_BANK_HI],
                         next_status[cspr_pkg::BIT_BANK_LO],
                         cspr_pkg::BANK_SHIFT'(0)}; // see RL7
         sfr_rdata_o <= next_rdata;
         sfr_hit_o <= next_hit;
      end
   end

   // =======================================================
   // checks
   // parity bit follows the registered accumulator
   parity_track_a: assert property ( // see RL10
      @(posedge sys_clk_i) disable iff (rst_i)
      status_o[cspr_pkg::BIT_PARITY] == ^acc_o)
      else $error("parity bit disagrees with accumulator");
   // the wide pointer is the two bytes side by side
   pointer_join_a: assert property ( // see RL3
      @(posedge sys_clk_i) disable iff (rst_i)
      indirect_data_pointer_o == {data_pointer_high, data_pointer_low})
      else $error("indirect pointer not formed from bytes");
   // bank base is the select bits times eight
   bank_window_a: assert property ( // see RL7
      @(posedge sys_clk_i) disable iff (rst_i)
      bank_base_o == {status_o[cspr_pkg::BIT_BANK_HI],
                      status_o[cspr_pkg::BIT_BANK_LO],
                      cspr_pkg::BANK_SHIFT'(0)})
      else $error("bank window does not match select bits");
   // every reported operation replaces the carry flag
   carry_update_a: assert property ( // see RL4
      @(posedge sys_clk_i) disable iff (rst_i)
      alu_valid_i && alu_i.op != cspr_pkg::CSPR_OP_NONE
      |=> status_o[cspr_pkg::BIT_CARRY] == $past(alu_i.carry))
      else $error("carry flag not updated by arithmetic");
   // every reported operation replaces the half carry flag
   half_update_a: assert property ( // see RL5
      @(posedge sys_clk_i) disable iff (rst_i)
      alu_valid_i && alu_i.op != cspr_pkg::CSPR_OP_NONE
      |=> status_o[cspr_pkg::BIT_HALF] == $past(alu_i.half_carry))
      else $error("half carry flag not updated");
   // add, add with carry and subtract report signed overflow
   add_ovfl_a: assert property ( // see RL8, RL9
      @(posedge sys_clk_i) disable iff (rst_i)
      alu_valid_i && alu_i.op inside {cspr_pkg::CSPR_OP_ADD,
         cspr_pkg::CSPR_OP_ADDC, cspr_pkg::CSPR_OP_SUBB}
      |=> status_o[cspr_pkg::BIT_OVFL] == $past(alu_i.sign_ovfl))
      else $error("add or subtract overflow flag wrong");
   // multiply overflow means a product above one byte
   mul_ovfl_a: assert property ( // see RL8, RL9
      @(posedge sys_clk_i) disable iff (rst_i)
      alu_valid_i && alu_i.op == cspr_pkg::CSPR_OP_MUL
      |=> status_o[cspr_pkg::BIT_OVFL]
          == ($past(alu_i.product) > 16'(cspr_pkg::PRODUCT_LIMIT)))
      else $error("multiply overflow flag wrong");
   // divide overflow means a zero divisor
   div_ovfl_a: assert property ( // see RL8, RL9
      @(posedge sys_clk_i) disable iff (rst_i)
      alu_valid_i && alu_i.op == cspr_pkg::CSPR_OP_DIV
      |=> status_o[cspr_pkg::BIT_OVFL]
          == ($past(alu_i.divisor) == cspr_pkg::RST_ZERO))
      else $error("divide overflow flag wrong");
   // software byte write reaches the user flags
   user_flag_a: assert property ( // see RL6
      @(posedge sys_clk_i) disable iff (rst_i)
      sfr_i.wr && sfr_i.addr == cspr_pkg::ADDR_STATUS && !alu_valid_i
      |=> status_o[cspr_pkg::BIT_UFLAG0]
             == $past(sfr_i.wdata[cspr_pkg::BIT_UFLAG0])
          && status_o[cspr_pkg::BIT_UFLAG1]
             == $past(sfr_i.wdata[cspr_pkg::BIT_UFLAG1]))
      else $error("user flags not written by software");
   // datapath result lands in the accumulator
   acc_source_a: assert property ( // see RL12
      @(posedge sys_clk_i) disable iff (rst_i)
      acc_wr_i |=> acc_o == $past(acc_wdata_i))
      else $error("accumulator did not take datapath result");
   // status word reads back at its fixed address
   status_read_a: assert property ( // see RL13
      @(posedge sys_clk_i) disable iff (rst_i)
      sfr_raddr_i == cspr_pkg::ADDR_STATUS
      |=> sfr_rdata_o == $past(status_o))
      else $error("status word read back wrong");
   // next push address sits one above the stack top
   push_addr_a: assert property ( // see RL1
      @(posedge sys_clk_i) disable iff (rst_i)
      push_addr_o == stack_top_pointer_o + cspr_pkg::ONE_BYTE)
      else $error("push address not one above stack top");
   // accumulator and status word clear on reset
   acc_reset_a: assert property ( // see RL12
      @(posedge sys_clk_i)
      rst_i |=> acc_o == cspr_pkg::RST_ZERO
          && status_o == cspr_pkg::RST_ZERO)
      else $error("accumulator or status not cleared by reset");
endmodule

/* cspr_pkg.sv */
// constants and carrier types for the core special register block
//
// Contract
// RL1 - push increments the stack top pointer before the byte is written
// RL2 - stack top pointer resets to 0x07
// RL3 - data pointer low and high bytes form one 16-bit indirect pointer
// RL4 - carry flag bit 7 set on carry or borrow, else cleared
// RL5 - half-carry bit 6 set on nibble carry or borrow, else cleared
// RL6 - status bits 5 and 1 are plain software flags, bit addressable
// RL7 - bank select bits 4:3 pick one of four eight-byte register windows
// RL8 - overflow bit 2 set on signed overflow, product over 255, divide by 0
// RL9 - overflow cleared by add, addc, subb, mul, div otherwise
// RL10 - status bit 0 always shows odd parity of accumulator, read only
// RL11 - software never writes one to reserved bits; they reset to zero
// RL12 - accumulator is arithmetic operand and result, resets zero, bit access
// RL13 - these registers decode at fixed addresses on every page
// RL14 - pop reads at the stack top pointer then decrements it
package cspr_pkg;
   // =======================================================
   // register addresses
   localparam logic [7:0] ADDR_STACK_TOP = 8'h81;
   localparam logic [7:0] ADDR_INDIRECT_DATA_POINTER_LOW = 8'h82;
   localparam logic [7:0] ADDR_INDIRECT_DATA_POINTER_HIGH = 8'h83;
   localparam logic [7:0] ADDR_STATUS = 8'hD0;
   localparam logic [7:0] ADDR_WORK = 8'hE0;
   // =======================================================
   // reset values
   localparam logic [7:0] RST_STACK_TOP = 8'h07;
   localparam logic [7:0] RST_ZERO = 8'h00;
   // =======================================================
   // status word bit positions
   localparam int BIT_CARRY = 7;
   localparam int BIT_HALF = 6;
   localparam int BIT_UFLAG0 = 5;
   localparam int BIT_BANK_HI = 4;
   localparam int BIT_BANK_LO = 3;
   localparam int BIT_OVFL = 2;
   localparam int BIT_UFLAG1 = 1;
   localparam int BIT_PARITY = 0;
   localparam logic [7:0] STATUS_SW_MASK = 8'hFE;
   localparam logic [7:0] PRODUCT_LIMIT = 8'hFF;
   localparam logic [7:0] ONE_BYTE = 8'h01;
   localparam logic [2:0] BANK_SHIFT = 3'h3;
   // =======================================================
   // arithmetic operation kinds reported by the datapath
   typedef enum logic [2:0] {
      CSPR_OP_NONE, CSPR_OP_ADD, CSPR_OP_ADDC, CSPR_OP_SUBB,
      CSPR_OP_MUL, CSPR_OP_DIV, CSPR_OP_OTHER
   } cspr_op_t;
   // result report from the arithmetic unit
   typedef struct packed {
      cspr_op_t op;
      logic [7:0] result;
      logic carry;
      logic half_carry;
      logic sign_ovfl;
      logic [15:0] product;
      logic [7:0] divisor;
   } cspr_alu_t;
   // software access to the special register space
   typedef struct packed {
      logic wr;
      logic bit_wr;
      logic [7:0] addr;
      logic [7:0] wdata;
      logic [2:0] bit_sel;
      logic bit_val;
   } cspr_sfr_t;
endpackage

/* cspr_stack.sv */
// stack top pointer with push and pop sequencing
`timescale 1ns/10ps
module cspr_stack #(
   parameter logic [7:0] RESET_VALUE = cspr_pkg::RST_STACK_TOP
) (
   // clock and reset
   input wire logic sys_clk_i,
   input wire logic rst_i,
   // control
   input wire logic push_i,
   input wire logic pop_i,
   input wire logic load_i,
   input wire logic [7:0] load_val_i,
   // state
   output logic [7:0] ptr_o,
   output logic [7:0] push_addr_o
);
   logic [7:0] next_ptr;
   logic [7:0] next_push_addr;

   // next pointer: push pre-increments, pop post-decrements
   always_comb begin
      next_ptr = ptr_o;
      if (push_i && !pop_i) begin
         next_ptr = ptr_o + cspr_pkg::ONE_BYTE; // see RL1
      end else if (pop_i && !push_i) begin
         next_ptr = ptr_o - cspr_pkg::ONE_BYTE; // see RL14
      end else if (load_i) begin
         next_ptr = load_val_i;
      end
      next_push_addr = next_ptr + cspr_pkg::ONE_BYTE;
   end

   // register the pointer
   always_ff @(posedge sys_clk_i) begin
      if (rst_i) begin
         ptr_o <= RESET_VALUE; // see RL2
         push_addr_o <= RESET_VALUE + cspr_pkg::ONE_BYTE;
      end else begin
         ptr_o <= next_ptr;
         push_addr_o <= next_push_addr;
      end
   end

   // push moves the pointer up by one
   push_step_a: assert property ( // see RL1
      @(posedge sys_clk_i) disable iff (rst_i)
      push_i && !pop_i |=> ptr_o == $past(ptr_o) + cspr_pkg::ONE_BYTE)
      else $error("push did not increment pointer");
   // pop moves the pointer down by one
   pop_step_a: assert property ( // see RL14
      @(posedge sys_clk_i) disable iff (rst_i)
      pop_i && !push_i |=> ptr_o == $past(ptr_o) - cspr_pkg::ONE_BYTE)
      else $error("pop did not decrement pointer");
   // reset value after release
   stack_reset_a: assert property ( // see RL2
      @(posedge sys_clk_i)
      rst_i |=> ptr_o == RESET_VALUE)
      else $error("stack pointer reset value wrong");
endmodule

/* cspr_dp_model.sv */
// behavioural model of the execution datapath that reports flag sources
`timescale 1ns/10ps
module cspr_dp_model (
   // operation request
   input wire cspr_pkg::cspr_op_t op_i,
   input wire logic [7:0] a_i,
   input wire logic [7:0] b_i,
   input wire logic cin_i,
   // report to the register block
   output cspr_pkg::cspr_alu_t alu_o
);
   logic [8:0] sum;
   logic [4:0] nib;
   logic c;
   // arithmetic and flag sources of each operation
   always_comb begin
      alu_o = '0;
      alu_o.op = op_i;
      c = cin_i & (op_i != cspr_pkg::CSPR_OP_ADD);
      sum = {1'b0, a_i} + {1'b0, b_i} + {8'h00, c};
      nib = {1'b0, a_i[3:0]} + {1'b0, b_i[3:0]} + {4'h0, c};
      if (op_i == cspr_pkg::CSPR_OP_SUBB) begin
         sum = {1'b0, a_i} - {1'b0, b_i} - {8'h00, c};
         nib = {1'b0, a_i[3:0]} - {1'b0, b_i[3:0]} - {4'h0, c};
      end
      case (op_i)
         cspr_pkg::CSPR_OP_ADD, cspr_pkg::CSPR_OP_ADDC,
         cspr_pkg::CSPR_OP_SUBB: begin
            alu_o.result = sum[7:0];
            alu_o.carry = sum[8];
            alu_o.half_carry = nib[4];
            alu_o.sign_ovfl = (sum[7] != a_i[7]) &
               ((a_i[7] == b_i[7]) ^ (op_i == cspr_pkg::CSPR_OP_SUBB));
         end
         cspr_pkg::CSPR_OP_MUL: alu_o.product = a_i * b_i;
         cspr_pkg::CSPR_OP_DIV: alu_o.divisor = b_i;
         default: ;
      endcase
   end
endmodule

/* cspr_core_regs_tb.sv */
// self-checking bench for the core special register block
`timescale 1ns/10ps
module cspr_core_regs_tb;
   logic sys_clk_i = 1'b0;
   logic rst_i = 1'b1;
   cspr_pkg::cspr_sfr_t sfr = '0;
   logic [7:0] raddr = 8'h00;
   logic acc_wr = 1'b0;
   logic [7:0] acc_wd = 8'h00;
   logic alu_valid = 1'b0;
   logic push = 1'b0;
   logic pop = 1'b0;
   cspr_pkg::cspr_op_t op = cspr_pkg::CSPR_OP_NONE;
   logic [7:0] opa = 8'h00;
   logic [7:0] opb = 8'h00;
   cspr_pkg::cspr_alu_t alu;
   logic [7:0] rdata, acc, status, ptr, paddr, v;
   logic hit;
   logic [15:0] indirect_data_pointer;
   logic [4:0] bank;
   logic [7:0] program_status_word = 8'h00;
   logic [7:0] eacc = 8'h00;
   logic [7:0] ad[5] = '{8'h81, 8'h82, 8'h83, 8'hD0, 8'hE0};
   int failures = 0;
   int n_tests = 0;
   // clock
   initial begin
      forever #12.5 sys_clk_i = ~sys_clk_i;
   end
   cspr_core_regs u_cspr_core_regs (.sys_clk_i(sys_clk_i), .rst_i(rst_i),
      .sfr_i(sfr), .sfr_raddr_i(raddr), .sfr_rdata_o(rdata),
      .sfr_hit_o(hit), .acc_wr_i(acc_wr), .acc_wdata_i(acc_wd),
      .alu_valid_i(alu_valid), .alu_i(alu), .push_i(push),
      .pop_i(pop), .acc_o(acc), .status_o(status),
      .indirect_data_pointer_o(indirect_data_pointer), .stack_top_pointer_o(ptr),
      .push_addr_o(paddr), .bank_base_o(bank));
   cspr_dp_model u_cspr_dp_model (.op_i(op), .a_i(opa), .b_i(opb),
      .cin_i(status[7]), .alu_o(alu));
   // expected status word after one arithmetic report
   function automatic logic [7:0] exp_psw(input cspr_pkg::cspr_alu_t a,
                                          input logic [7:0] p);
      logic [7:0] r;
      r = p;
      r[7] = a.carry;
      r[6] = a.half_carry;
      case (a.op)
         cspr_pkg::CSPR_OP_MUL: r[2] = a.product[15:8] != 8'h00;
         cspr_pkg::CSPR_OP_DIV: r[2] = a.divisor == 8'h00;
         cspr_pkg::CSPR_OP_OTHER: ;
         default: r[2] = a.sign_ovfl;
      endcase
      return r;
   endfunction
   task automatic chk(input string n, input logic [15:0] e,
                      input logic [15:0] g);
      n_tests++;
      if (g !== e) begin
         failures++;
         $display("[FAIL] %s expected %h seen %h", n, e, g);
      end
   endtask
   task automatic chk_st;
      chk("status", {program_status_word[7:1], ^eacc}, status);
   endtask
   // one-cycle software write strobe
   task automatic drive(input logic w, input logic b, input logic [7:0] a,
                        input logic [7:0] d, input logic [2:0] s);
      @(negedge sys_clk_i);
      sfr = {w, b, a, d, s, d[0]};
      @(negedge sys_clk_i);
      sfr = '0;
   endtask
   // one-cycle push and pop strobes from the datapath
   task automatic stk(input logic u, input logic o);
      @(negedge sys_clk_i);
      push = u;
      pop = o;
      @(negedge sys_clk_i);
      push = 1'b0;
      pop = 1'b0;
   endtask
   task automatic rd(input logic [7:0] a, input logic [7:0] e,
                     input logic h);
      @(negedge sys_clk_i);
      raddr = a;
      @(negedge sys_clk_i);
      chk("rdata", {8'h00, e}, {8'h00, rdata});
      chk("hit", {15'h0000, h}, {15'h0000, hit});
   endtask
   task automatic acc_w(input logic [7:0] d);
      @(negedge sys_clk_i);
      acc_wr = 1'b1;
      acc_wd = d;
      eacc = d;
      @(negedge sys_clk_i);
      acc_wr = 1'b0;
      chk("acc", {8'h00, d}, {8'h00, acc});
   endtask
   task automatic alu_do(input int o, input logic [7:0] a,
                         input logic [7:0] b);
      @(negedge sys_clk_i);
      op = cspr_pkg::cspr_op_t'(o);
      opa = a;
      opb = b;
      alu_valid = 1'b1;
      #1 program_status_word = exp_psw(alu, program_status_word);
      @(negedge sys_clk_i);
      alu_valid = 1'b0;
      chk_st();
   endtask
   task automatic test_done;
      $display("failures %0d checks %0d", failures, n_tests);
      if (failures == 0 && n_tests > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask
   // watchdog
   initial begin
      #(25 * 6000);
      failures++;
      test_done();
   end
   initial begin
      void'($urandom(15311));
      repeat (5) @(negedge sys_clk_i);
      rst_i = 1'b0;
      for (int i = 0; i < 5; i++) begin
         rd(ad[i], (i == 0) ? 8'h07 : 8'h00, 1'b1);
      end
      rd(8'hE1, 8'h00, 1'b0);
      chk("push addr", 16'h0008, {8'h00, paddr});
      v = 8'($urandom);
      drive(1'b1, 1'b0, 8'h82, v, 3'h0);
      drive(1'b1, 1'b0, 8'h83, ~v, 3'h0);
      chk("indirect_data_pointer", {~v, v}, indirect_data_pointer);
      stk(1'b1, 1'b0);
      chk("push", 16'h0809, {ptr, paddr});
      stk(1'b1, 1'b0);
      stk(1'b0, 1'b1);
      chk("pop", 16'h0809, {ptr, paddr});
      stk(1'b1, 1'b1);
      chk("push pop", 16'h0809, {ptr, paddr});
      drive(1'b1, 1'b0, 8'h81, 8'hFF, 3'h0);
      stk(1'b1, 1'b0);
      chk("wrap", 16'h0001, {ptr, paddr});
      // collisions: push beats a stack write, datapath beats software
      @(negedge sys_clk_i);
      sfr = {1'b1, 1'b0, 8'h81, 8'h40, 3'h0, 1'b0};
      push = 1'b1;
      @(negedge sys_clk_i);
      sfr = {1'b1, 1'b0, 8'hE0, 8'h5A, 3'h0, 1'b0};
      push = 1'b0;
      acc_wr = 1'b1;
      acc_wd = 8'hC3;
      eacc = 8'hC3;
      chk("push wins", 16'h0102, {ptr, paddr});
      @(negedge sys_clk_i);
      sfr = '0;
      acc_wr = 1'b0;
      chk("acc wins", 16'h00C3, {8'h00, acc});
      for (int i = 0; i < 4; i++) begin
         v = {3'h0, 2'(i), 3'h1};
         drive(1'b1, 1'b0, 8'hD0, v, 3'h0);
         program_status_word = v & 8'hFE;
         chk_st();
         chk("bank", {11'h000, 2'(i), 3'h0}, {11'h000, bank});
      end
      drive(1'b0, 1'b1, 8'hD0, 8'h01, 3'h5);
      drive(1'b0, 1'b1, 8'hD0, 8'h01, 3'h1);
      drive(1'b0, 1'b1, 8'hD0, 8'h01, 3'h0);
      program_status_word = program_status_word | 8'h22;
      chk_st();
      acc_w(8'h00);
      drive(1'b0, 1'b1, 8'hE0, 8'h01, 3'h7);
      eacc = 8'h80;
      chk("acc bit", 16'h0080, {8'h00, acc});
      chk_st();
      for (int i = 0; i < 12; i++) begin
         acc_w((i == 0) ? 8'hFF : 8'($urandom));
         chk_st();
      end
      alu_do(1, 8'h7F, 8'h01);
      alu_do(3, 8'h00, 8'h01);
      alu_do(4, 8'h10, 8'h10);
      alu_do(4, 8'h0F, 8'h11);
      alu_do(5, 8'h20, 8'h00);
      alu_do(5, 8'h20, 8'h01);
      for (int i = 0; i < 40; i++) begin
         alu_do($urandom_range(6, 1), 8'($urandom), 8'($urandom));
      end
      rd(8'hD0, {program_status_word[7:1], ^eacc}, 1'b1);
      // second reset in mid-run brings every register back
      @(negedge sys_clk_i);
      rst_i = 1'b1;
      repeat (2) @(negedge sys_clk_i);
      rst_i = 1'b0;
      eacc = 8'h00;
      program_status_word = 8'h00;
      for (int i = 0; i < 5; i++) begin
         rd(ad[i], (i == 0) ? 8'h07 : 8'h00, 1'b1);
      end
      chk("reset push addr", 16'h0008, {8'h00, paddr});
      chk_st();
      test_done();
   end
endmodule
